/* rtl/sdmmu_unit.sv */
/*
 * Signed dual halfword and upper-word multiply execution unit.
 * Assumes the decoder presents one operation per issue pulse with operands
 * already read from the register file, and that it has already evaluated
 * the condition code. Results come back one cycle later with write enables.
 */
// Operation
// - Dual forms split each operand into two signed halfwords, two 16x16 products.
// - Swapped variant exchanges second operand halfwords; otherwise bottom-bottom, top-top.
// - Dual subtract-accumulate subtracts top product from bottom product.
// - Short subtract-accumulate adds signed 32-bit accumulate operand, writes destination.
// - Long form adds difference to 64-bit accumulator and writes it back.
// - Low register carries accumulator bits 31..0, high register bits 63..32.
// - Short subtract-accumulate sets saturation flag on accumulate overflow only.
// - Dual subtract-accumulate leaves negative, zero, carry, overflow flags alone.
// - Upper-word forms multiply signed words, optionally add rounding constant, take top.
// - Upper-word accumulate adds accumulate operand to the extracted upper word.
// - Upper-word subtract takes extracted upper word from accumulate operand.
// - Plain upper-word multiply writes only the extracted upper word.
// - Upper-word operations never modify condition flags.
// - Dual multiply-add writes the sum of both products.
// - Dual multiply-subtract writes bottom product minus top product.
// - Dual multiply-add sets saturation flag when the product sum overflows.
// - Saturation flag is sticky until an explicit software clear.
`timescale 1ns/1ps
`include "sdmmu_defs.svh"

module sdmmu_unit
  import sdmmu_pkg::*;
#(
  parameter int WORD_W = `SDMMU_WORD_W
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire logic cond_pass,
  input wire sdmmu_op_t op_select,
  input wire logic swap_halves,
  input wire logic round_enable,
  input wire logic [WORD_W-1:0] first_operand,
  input wire logic [WORD_W-1:0] second_operand,
  input wire logic [WORD_W-1:0] accumulate_operand,
  input wire logic [WORD_W-1:0] accum_low_reg,
  input wire logic [WORD_W-1:0] accum_high_reg,
  input wire logic sat_clear,
  input wire logic [3:0] cond_flags_in,
  output logic result_valid,
  output logic dest_write,
  output logic [WORD_W-1:0] dest_result,
  output logic long_write,
  output logic [WORD_W-1:0] accum_low_result,
  output logic [WORD_W-1:0] accum_high_result,
  output logic sat_flag,
  output logic [3:0] cond_flags_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  initial
  begin
    if (WORD_W != `SDMMU_WORD_W)
    begin
      $error("sdmmu_unit: only a 32-bit word is supported");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic valid;
    logic dest_write;
    logic [WORD_W-1:0] dest_result;
    logic long_write;
    logic [WORD_W-1:0] low_result;
    logic [WORD_W-1:0] high_result;
    logic sat;
  } sdmmu_state_t;

  sdmmu_state_t state_reg;
  sdmmu_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Multipliers

  logic signed [WORD_W-1:0] bottom_product;
  logic signed [WORD_W-1:0] top_product;
  logic [WORD_W-1:0] upper_word;

  sdmmu_dual_half_mul #(
    .HALF_W(WORD_W / 2)
  ) u_dual (
    .first_operand(first_operand),
    .second_operand(second_operand),
    .swap_halves(swap_halves),
    .bottom_product(bottom_product),
    .top_product(top_product)
  );

  sdmmu_word_mul #(
    .WORD_W(WORD_W)
  ) u_word (
    .first_operand(first_operand),
    .second_operand(second_operand),
    .round_enable(round_enable),
    .upper_word(upper_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  // Sums carry two guard bits so overflow is judged on the exact value.
  logic signed [WORD_W+1:0] prod_diff;
  logic signed [WORD_W+1:0] prod_sum;
  logic signed [WORD_W+1:0] acc_sum;
  logic [2*WORD_W-1:0] long_acc;
  logic [2*WORD_W-1:0] long_sum;
  logic signed [WORD_W+1:0] word_min;
  logic signed [WORD_W+1:0] word_max;

  assign word_max = {3'h0, {(WORD_W-1){1'b1}}};
  assign word_min = ~word_max;
  // Difference of two 16x16 products always fits 32 bits.
  assign prod_diff = (WORD_W+2)'(bottom_product) - (WORD_W+2)'(top_product);
  assign prod_sum = (WORD_W+2)'(bottom_product) + (WORD_W+2)'(top_product);
  assign acc_sum = prod_diff + (WORD_W+2)'($signed(accumulate_operand));
  assign long_acc = {accum_high_reg, accum_low_reg};
  assign long_sum = long_acc + (2*WORD_W)'(prod_diff);

  function automatic logic out_of_range(input logic signed [WORD_W+1:0] value, input logic signed [WORD_W+1:0] lo,
                                        input logic signed [WORD_W+1:0] hi);
    out_of_range = (value < lo) || (value > hi);
  endfunction : out_of_range

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic overflow;
    overflow = 1'b0;
    state_next = state_reg;
    state_next.valid = issue_valid;
    state_next.dest_write = 1'b0;
    state_next.long_write = 1'b0;
    if (issue_valid && cond_pass)
    begin
      unique case (op_select)
        SDMMU_OP_NONE:
        begin
          state_next.dest_write = 1'b0;
        end
        SDMMU_OP_DUAL_MUL_SUB_ACC:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = acc_sum[WORD_W-1:0];
          overflow = out_of_range(acc_sum, word_min, word_max);
        end
        SDMMU_OP_DUAL_MUL_SUB_ACC_LONG:
        begin
          // The long form never touches the saturation flag.
          state_next.long_write = 1'b1;
          state_next.low_result = long_sum[WORD_W-1:0];
          state_next.high_result = long_sum[2*WORD_W-1:WORD_W];
        end
        SDMMU_OP_DUAL_MUL_ADD:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = prod_sum[WORD_W-1:0];
          overflow = out_of_range(prod_sum, word_min, word_max);
        end
        SDMMU_OP_DUAL_MUL_SUB:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = prod_diff[WORD_W-1:0];
        end
        SDMMU_OP_UPPER_WORD_MUL:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = upper_word;
        end
        SDMMU_OP_UPPER_WORD_MUL_ACC:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = accumulate_operand + upper_word;
        end
        SDMMU_OP_UPPER_WORD_MUL_SUB:
        begin
          state_next.dest_write = 1'b1;
          state_next.dest_result = accumulate_operand - upper_word;
        end
        default:
        begin
          state_next.dest_write = 1'b0;
        end
      endcase
    end
    // A new overflow wins over a clear in the same cycle.
    if (overflow)
    begin
      state_next.sat = 1'b1;
    end
    else if (sat_clear)
    begin
      state_next.sat = `SDMMU_SAT_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign result_valid = state_reg.valid;
  assign dest_write = state_reg.dest_write;
  assign dest_result = state_reg.dest_result;
  assign long_write = state_reg.long_write;
  assign accum_low_result = state_reg.low_result;
  assign accum_high_result = state_reg.high_result;
  assign sat_flag = state_reg.sat;
  // Condition flags pass straight through; no operation here alters them.
  assign cond_flags_out = cond_flags_in;

endmodule : sdmmu_unit

/* pkg/sdmmu_defs.svh */
/*
 * Constants for the signed dual and upper-word multiply unit.
 * Assumes inclusion by bare name from any design file; definitions only.
 */
`ifndef SDMMU_DEFS_SVH
`define SDMMU_DEFS_SVH

`define SDMMU_WORD_W 32
`define SDMMU_HALF_W 16
`define SDMMU_LONG_W 64
`define SDMMU_ROUND_CONST 64'h0000_0000_8000_0000
`define SDMMU_LATENCY 1
`define SDMMU_SAT_RESET 1'b0

`endif

/* pkg/sdmmu_pkg.sv */
/*
 * Types for the signed dual and upper-word multiply unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sdmmu_pkg;

  // Operation select presented by the decoder.
  typedef enum logic [3:0] {
    SDMMU_OP_NONE = 4'h0,
    SDMMU_OP_DUAL_MUL_SUB_ACC = 4'h1,
    SDMMU_OP_DUAL_MUL_SUB_ACC_LONG = 4'h2,
    SDMMU_OP_DUAL_MUL_ADD = 4'h3,
    SDMMU_OP_DUAL_MUL_SUB = 4'h4,
    SDMMU_OP_UPPER_WORD_MUL = 4'h5,
    SDMMU_OP_UPPER_WORD_MUL_ACC = 4'h6,
    SDMMU_OP_UPPER_WORD_MUL_SUB = 4'h7
  } sdmmu_op_t;

endpackage : sdmmu_pkg

/* rtl/sdmmu_dual_half_mul.sv */
/*
 * Dual signed 16x16 halfword multiplier with optional operand swap.
 * Assumes a purely combinational context; the caller registers results.
 */
`timescale 1ns/1ps
`include "sdmmu_defs.svh"

module sdmmu_dual_half_mul
  import sdmmu_pkg::*;
#(
  parameter int HALF_W = `SDMMU_HALF_W
)
(
  input wire logic [2*HALF_W-1:0] first_operand,
  input wire logic [2*HALF_W-1:0] second_operand,
  input wire logic swap_halves,
  output logic signed [2*HALF_W-1:0] bottom_product,
  output logic signed [2*HALF_W-1:0] top_product
);

  initial
  begin
    if (HALF_W < 2)
    begin
      $error("sdmmu_dual_half_mul: HALF_W too small");
    end
  end

  logic signed [HALF_W-1:0] a_low;
  logic signed [HALF_W-1:0] a_high;
  logic signed [HALF_W-1:0] b_low;
  logic signed [HALF_W-1:0] b_high;

  assign a_low = first_operand[HALF_W-1:0];
  assign a_high = first_operand[2*HALF_W-1:HALF_W];
  // Swapped form pairs bottom with top and top with bottom.
  assign b_low = swap_halves ? second_operand[2*HALF_W-1:HALF_W] : second_operand[HALF_W-1:0];
  assign b_high = swap_halves ? second_operand[HALF_W-1:0] : second_operand[2*HALF_W-1:HALF_W];

  // A 16x16 signed product always fits 32 bits, so no overflow here.
  assign bottom_product = a_low * b_low;
  assign top_product = a_high * b_high;

endmodule : sdmmu_dual_half_mul

/* rtl/sdmmu_word_mul.sv */
/*
 * Signed 32x32 multiply returning the upper word, rounded or truncated.
 * Assumes a purely combinational context; the caller registers results.
 */
`timescale 1ns/1ps
`include "sdmmu_defs.svh"

module sdmmu_word_mul
  import sdmmu_pkg::*;
#(
  parameter int WORD_W = `SDMMU_WORD_W
)
(
  input wire logic [WORD_W-1:0] first_operand,
  input wire logic [WORD_W-1:0] second_operand,
  input wire logic round_enable,
  output logic [WORD_W-1:0] upper_word
);

  initial
  begin
    if (WORD_W != `SDMMU_WORD_W)
    begin
      $error("sdmmu_word_mul: rounding constant assumes a 32-bit word");
    end
  end

  logic signed [2*WORD_W-1:0] full_product;
  logic [2*WORD_W-1:0] rounded_product;

  assign full_product = $signed(first_operand) * $signed(second_operand);
  // Rounding adds half an upper-word step before the upper bits are kept.
  assign rounded_product = round_enable ? (full_product + `SDMMU_ROUND_CONST) : full_product;
  assign upper_word = rounded_product[2*WORD_W-1:WORD_W];

endmodule : sdmmu_word_mul

/* tb/sdmmu_unit_properties.sv */
/* Port checker for the multiply unit.
   Assumes it is bound to the unit and sees its ports only. */
`timescale 1ns/1ps
module sdmmu_unit_properties
  import sdmmu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire logic cond_pass,
  input wire sdmmu_op_t op_select,
  input wire logic sat_clear,
  input wire logic [3:0] cond_flags_in,
  input wire logic result_valid,
  input wire logic dest_write,
  input wire logic long_write,
  input wire logic sat_flag,
  input wire logic [3:0] cond_flags_out
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic ok_issue;
  assign ok_issue = issue_valid && cond_pass;
  valid_follows_a: assert property (result_valid == $past(issue_valid))
    else $error("result strobe not one cycle after issue");
  write_cause_a: assert property (dest_write || long_write |-> $past(ok_issue))
    else $error("write without a passing issue");
  refused_quiet_a: assert property (issue_valid && !cond_pass |=> !dest_write && !long_write)
    else $error("refused issue wrote a result");
  refused_sat_a: assert property (issue_valid && !cond_pass && !sat_clear |=> $stable(sat_flag))
    else $error("refused issue moved the saturation flag");
  sat_sticky_a: assert property (sat_flag && !sat_clear |=> sat_flag)
    else $error("saturation flag dropped without clear");
  sat_cause_a: assert property ($rose(sat_flag) |-> $past(ok_issue &&
    op_select inside {SDMMU_OP_DUAL_MUL_SUB_ACC, SDMMU_OP_DUAL_MUL_ADD}))
    else $error("saturation set by a wrong operation");
  flags_pass_a: assert property (cond_flags_out == cond_flags_in)
    else $error("condition flags altered");
  long_route_a: assert property (ok_issue && op_select == SDMMU_OP_DUAL_MUL_SUB_ACC_LONG
    |=> long_write && !dest_write)
    else $error("long result not written as a pair");
  upper_route_a: assert property (ok_issue && op_select inside {SDMMU_OP_UPPER_WORD_MUL,
    SDMMU_OP_UPPER_WORD_MUL_ACC, SDMMU_OP_UPPER_WORD_MUL_SUB} |=> dest_write && !long_write)
    else $error("upper word result not written");
endmodule : sdmmu_unit_properties

/* tb/sdmmu_regfile_model.sv */
/* Register file write-back side of the unit; counts writes.
   Assumes the unit's clock and reset. */
`timescale 1ns/1ps
module sdmmu_regfile_model
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic dest_write,
  input wire logic long_write,
  output logic [31:0] n_writes
);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      n_writes <= 32'h0;
    else if (dest_write || long_write)
      n_writes <= n_writes + 32'h1;
  end
endmodule : sdmmu_regfile_model

/* tb/signed_dual_and_msw_multiply_unit_bench.sv */
/* Self-checking bench for the multiply unit.
   Assumes the checker and the write-back model are compiled first. */
`timescale 1ns/1ps
module signed_dual_and_msw_multiply_unit_bench;
  import sdmmu_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, issue_valid = 1'b0, cond_pass = 1'b0;
  logic swap_halves = 1'b0, round_enable = 1'b0, sat_clear = 1'b0, sat_e = 1'b0;
  sdmmu_op_t op_select = SDMMU_OP_NONE;
  logic [31:0] first_operand = 32'h0, second_operand = 32'h0, accumulate_operand = 32'h0;
  logic [31:0] accum_low_reg = 32'h0, accum_high_reg = 32'h0, dest_result, accum_low_result;
  logic [31:0] accum_high_result, n_writes;
  logic [3:0] cond_flags_in = 4'h0, cond_flags_out;
  logic result_valid, dest_write, long_write, sat_flag;
  int n_fail = 0, num_checks = 0, n_wr = 0;
  always #12.5 sys_clk = ~sys_clk;
  sdmmu_unit dut_u (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .issue_valid(issue_valid),
    .cond_pass(cond_pass),
    .op_select(op_select),
    .swap_halves(swap_halves),
    .round_enable(round_enable),
    .first_operand(first_operand),
    .second_operand(second_operand),
    .accumulate_operand(accumulate_operand),
    .accum_low_reg(accum_low_reg),
    .accum_high_reg(accum_high_reg),
    .sat_clear(sat_clear),
    .cond_flags_in(cond_flags_in),
    .result_valid(result_valid),
    .dest_write(dest_write),
    .dest_result(dest_result),
    .long_write(long_write),
    .accum_low_result(accum_low_result),
    .accum_high_result(accum_high_result),
    .sat_flag(sat_flag),
    .cond_flags_out(cond_flags_out)
  );
  sdmmu_regfile_model rf_u (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .dest_write(dest_write),
    .long_write(long_write),
    .n_writes(n_writes)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Drives one issue and checks its answer one cycle later; calls may run back to back.
  task automatic run(input logic [3:0] op, input logic sw, rd, cp, input logic [31:0] a, b, acc, hi);
    logic [31:0] bs;
    longint pb, pt, p, r;
    logic wr, lw;
    bs = sw ? {b[15:0], b[31:16]} : b;
    op_select = sdmmu_op_t'(op);
    swap_halves = sw;
    round_enable = rd;
    cond_pass = cp;
    first_operand = a;
    second_operand = b;
    accumulate_operand = acc;
    accum_low_reg = acc;
    accum_high_reg = hi;
    cond_flags_in = b[3:0];
    sat_clear = 1'b0;
    issue_valid = 1'b1;
    @(negedge sys_clk);
    pb = $signed(a[15:0]);
    pb = pb * $signed(bs[15:0]);
    pt = $signed(a[31:16]);
    pt = pt * $signed(bs[31:16]);
    p = $signed(a);
    p = (p * $signed(b) + (rd ? 64'sh80000000 : 64'sh0)) >>> 32;
    case (op)
      4'h1: r = pb - pt + $signed(acc);
      4'h2: r = {hi, acc} + pb - pt;
      4'h3: r = pb + pt;
      4'h4: r = pb - pt;
      4'h5: r = p;
      4'h6: r = $signed(acc) + p;
      4'h7: r = $signed(acc) - p;
      default: r = 0;
    endcase
    lw = cp && op == 4'h2;
    wr = cp && op inside {[4'h1:4'h7]} && !lw;
    if (cp && (op == 4'h1 || op == 4'h3) && r[63:31] != {33{r[31]}})
      sat_e = 1'b1;
    n_wr += 32'(wr || lw);
    chk(64'({dest_write, long_write, result_valid}), 64'({wr, lw, 1'b1}));
    chk(64'(cond_flags_out), 64'(cond_flags_in));
    chk(64'(sat_flag), 64'(sat_e));
    if (wr)
      chk(64'(dest_result), 64'(r[31:0]));
    if (lw)
      chk({accum_high_result, accum_low_result}, r);
  endtask : run
  task automatic idle(input logic clr);
    sat_clear = clr;
    issue_valid = 1'b0;
    @(negedge sys_clk);
    if (clr)
      sat_e = 1'b0;
    chk(64'({result_valid, sat_flag}), 64'({1'b0, sat_e}));
  endtask : idle
  ////////////////////////////////////////
  task automatic t_dual;
    run(4'h1, 1'b0, 1'b0, 1'b1, 32'h3FFFE, 32'hFFF90005, 32'h64, 32'h0);
    run(4'h4, 1'b1, 1'b0, 1'b1, 32'h3FFFE, 32'hFFF90005, 32'h0, 32'h0);
    run(4'h3, 1'b0, 1'b0, 1'b1, 32'h80008000, 32'h80008000, 32'h0, 32'h0);
    run(4'h1, 1'b0, 1'b0, 1'b1, 32'h3FFFE, 32'hFFF90005, 32'h64, 32'h0);
    idle(1'b0);
    idle(1'b1);
    run(4'h3, 1'b1, 1'b0, 1'b1, 32'h3FFFE, 32'hFFF90005, 32'h0, 32'h0);
    run(4'h1, 1'b1, 1'b0, 1'b1, 32'h3FFFE, 32'hFFF90005, 32'h80000000, 32'h0);
    idle(1'b1);
    $display("test dual done");
  endtask : t_dual
  task automatic t_long;
    run(4'h2, 1'b0, 1'b0, 1'b1, 32'h2, 32'h3, 32'hFFFFFFFF, 32'h1);
    run(4'h2, 1'b1, 1'b0, 1'b1, 32'h7FFF8000, 32'h10001, 32'h0, 32'h0);
    idle(1'b0);
    $display("test long done");
  endtask : t_long
  task automatic t_upper;
    for (int op = 5; op < 8; op++)
      for (int rd = 0; rd < 2; rd++)
      begin
        run(4'(op), 1'b0, 1'(rd), 1'b1, 32'h40000000, 32'h3, 32'h1, 32'h0);
        run(4'(op), 1'b0, 1'(rd), 1'b1, 32'h80000000, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h0);
      end
    idle(1'b0);
    $display("test upper done");
  endtask : t_upper
  task automatic t_cond;
    for (int op = 0; op < 16; op++)
      run(4'(op), 1'b0, 1'b0, op > 7, 32'h80008000, 32'h80008000, 32'h7FFFFFFF, 32'h0);
    idle(1'b0);
    $display("test refused done");
  endtask : t_cond
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    t_dual;
    t_long;
    t_upper;
    t_cond;
    chk(64'(n_writes), 64'(n_wr));
    report_and_stop;
  end
endmodule : signed_dual_and_msw_multiply_unit_bench
bind sdmmu_unit sdmmu_unit_properties chk_u (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .issue_valid(issue_valid),
  .cond_pass(cond_pass),
  .op_select(op_select),
  .sat_clear(sat_clear),
  .cond_flags_in(cond_flags_in),
  .result_valid(result_valid),
  .dest_write(dest_write),
  .long_write(long_write),
  .sat_flag(sat_flag),
  .cond_flags_out(cond_flags_out)
);
